/* File: shared/fpec_defines.svh */
// Constants of the flash program/erase control block.
// Assumes byte-wide serial transport and one system clock.
//
// Contract
// R1: Set erase execution error if array erase fails or settings altered on return.
// R2: Boot array selected by H'AA: erase fails, nothing erased.
// R3: Key error flag cleared for key H'5A, set otherwise, before erasing.
// R4: Block select error set when block number lies outside the array.
// R5: Success/fail flag: 0 erase ended without error, 1 error occurred.
// R6: Programming command is H'50, four address bytes, data, then checksum.
// R7: Host aligns address so its lowest byte is H'00 or H'80.
// R8: Host pads unused data positions with H'FF.
// R9: Address H'FFFFFFFF ends programming; return to waiting for selection.
// R10: Successful programming answers the single acknowledge byte H'06.
// R11: Failed programming answers H'D0 then one error code byte.
// R12: Codes: H'11 checksum, H'2A address outside array, H'53 write failure.
// R13: Sum of all command bytes including checksum must be zero.
// R14: Checksum or address error leaves flash contents untouched.
`ifndef FPEC_DEFINES_SVH
`define FPEC_DEFINES_SVH
// ----------------------------------------
// Serial protocol bytes
// ----------------------------------------
`define FPEC_CMD_PROG 8'h50
`define FPEC_RESP_ACK 8'h06
`define FPEC_RESP_ERR 8'hD0
`define FPEC_CODE_SUM 8'h11
`define FPEC_CODE_ADDR 8'h2A
`define FPEC_CODE_PROG 8'h53
`define FPEC_ALIGN_LO0 8'h00
`define FPEC_ALIGN_LO1 8'h80
`define FPEC_PAD_BYTE 8'hFF
`define FPEC_END_ADDR 32'hFFFFFFFF
`define FPEC_PROG_BYTES 128
`define FPEC_ADDR_BYTES 2'h3
// ----------------------------------------
// Erase checks
// ----------------------------------------
`define FPEC_KEY_OK 8'h5A
`define FPEC_SEL_BOOT 8'hAA
`define FPEC_NUM_BLOCKS 8
`endif

/* File: shared/fpec_pkg.sv */
// Types shared by the flash program/erase control modules.
// Assumes fpec_defines.svh sits on the include path.
`include "fpec_defines.svh"
package fpec_pkg;
  // ----------------------------------------
  // Serial command handler state
  // ----------------------------------------
  typedef enum logic [2:0] {ST_CMD, ST_ADDR, ST_DATA, ST_SUM, ST_WRITE, ST_ACK, ST_ERR, ST_CODE} fpec_st_t;
  typedef struct packed {
    fpec_st_t st;
    logic [7:0] cnt;
    logic [31:0] addr;
    logic [7:0] sum;
    logic [7:0] code;
    logic wfail;
    logic tx_valid;
    logic [7:0] tx_data;
    logic prog_end;
    logic wr_valid;
    logic [31:0] wr_addr;
    logic [7:0] wr_data;
    logic [7:0] erase_block;
  } fpec_main_t;
  // ----------------------------------------
  // Erase checker state
  // ----------------------------------------
  typedef enum logic [1:0] {ER_IDLE, ER_RUN} fpec_er_st_t;
  typedef struct packed {
    fpec_er_st_t st;
    logic start;
    logic altered;
    logic exec_err;
    logic key_err;
    logic blk_err;
    logic success_fail;
  } fpec_erase_t;
endpackage : fpec_pkg

/* File: shared/fpec_erase_if.sv */
// Erase request and result bundle between top and erase checker.
// Assumes both ends sit in the same clock domain.
`timescale 1ns/10ps
interface fpec_erase_if;
  logic req;
  logic [7:0] key;
  logic [7:0] block;
  logic [7:0] select;
  logic altered;
  logic start;
  logic done;
  logic fail;
  logic exec_err;
  logic key_err;
  logic blk_err;
  logic success_fail;
  logic busy;
  modport ctl (output req, key, block, select, altered, done, fail,
               input start, exec_err, key_err, blk_err, success_fail, busy);
  modport eng (input req, key, block, select, altered, done, fail,
               output start, exec_err, key_err, blk_err, success_fail, busy);
endinterface : fpec_erase_if

/* File: hdl/fpec_erase_check.sv */
// Erase request checker: key, block range and array selection.
// Assumes the array reports completion with a done pulse and fail level.
`timescale 1ns/10ps
`include "fpec_defines.svh"
module fpec_erase_check
  import fpec_pkg::*;
#(
  parameter int NUM_BLOCKS = `FPEC_NUM_BLOCKS
)(
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  fpec_erase_if.eng erase
);
  fpec_erase_t r, n;
  logic key_bad, blk_bad, boot_sel;

  // ----------------------------------------
  // Checks and sequencing
  // ----------------------------------------
  // Request checks, decoded continuously and latched only when a request is taken
  assign key_bad = (erase.key != `FPEC_KEY_OK);
  assign blk_bad = ({24'h000000, erase.block} >= 32'(NUM_BLOCKS));
  assign boot_sel = (erase.select == `FPEC_SEL_BOOT);

  always_comb
  begin
    n = r;
    n.start = 1'b0;
    unique case (r.st)
      ER_IDLE:
      begin
        if (erase.req)
        begin
          // R3: key check first
          n.key_err = key_bad;
          // R4: block range check
          n.blk_err = blk_bad;
          // R2: boot array refused
          n.exec_err = boot_sel;
          n.altered = 1'b0;
          // R5: any failure sets fail
          n.success_fail = key_bad | blk_bad | boot_sel;
          // Nothing starts unless every check passed
          if (!(key_bad | blk_bad | boot_sel))
          begin
            n.start = 1'b1;
            n.st = ER_RUN;
          end
        end
      end
      ER_RUN:
      begin
        // Setting changes seen at any time during the run stay recorded
        n.altered = r.altered | erase.altered;
        if (erase.done)
        begin
          // R1: array failure or altered settings
          n.exec_err = erase.fail | r.altered | erase.altered;
          // R5: outcome summary
          n.success_fail = erase.fail | r.altered | erase.altered;
          n.st = ER_IDLE;
        end
      end
    endcase
  end

  // Single state register
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
      r <= '0;
    else
      r <= n;
  end

  assign erase.start = r.start;
  assign erase.exec_err = r.exec_err;
  assign erase.key_err = r.key_err;
  assign erase.blk_err = r.blk_err;
  assign erase.success_fail = r.success_fail;
  assign erase.busy = (r.st == ER_RUN);

  // ----------------------------------------
  // Checks on behaviour
  // ----------------------------------------
  key_flag_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R3
    (r.st == ER_IDLE && erase.req) |=> (erase.key_err == (($past(erase.key)) != `FPEC_KEY_OK)))
    else $error("key check flag wrong");
  boot_no_start_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R2
    (r.st == ER_IDLE && erase.req && boot_sel) |=> (!erase.start && erase.exec_err && erase.success_fail))
    else $error("boot array erase not refused");
  block_flag_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R4
    (r.st == ER_IDLE && erase.req && blk_bad) |=> (erase.blk_err && !erase.busy))
    else $error("block range error missed");
  fail_sum_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R5
    (r.st == ER_IDLE) |-> (erase.success_fail == (erase.exec_err | erase.key_err | erase.blk_err)))
    else $error("success flag disagrees with errors");
  exec_err_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R1
    (erase.busy && erase.done && erase.fail) |=> (erase.exec_err && !erase.busy))
    else $error("erase failure not reported");
endmodule : fpec_erase_check

/* File: hdl/fpec_top.sv */
// Flash program/erase control: boot-mode 128-byte programming command handler
// plus erase result reporting. Serial bytes arrive already deserialised.
// Assumes one clock, the write port accepts one byte per valid/ready beat.
`timescale 1ns/10ps
`include "fpec_defines.svh"
module fpec_top
  import fpec_pkg::*;
#(
  parameter int PROG_BYTES = `FPEC_PROG_BYTES,
  parameter int NUM_BLOCKS = `FPEC_NUM_BLOCKS
)(
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_rx_valid,
  input wire logic [7:0] i_rx_data,
  output logic o_rx_ready,
  output logic o_tx_valid,
  output logic [7:0] o_tx_data,
  input wire logic i_tx_ready,
  input wire logic [31:0] i_array_base,
  input wire logic [31:0] i_array_size,
  output logic o_wr_valid,
  output logic [31:0] o_wr_addr,
  output logic [7:0] o_wr_data,
  input wire logic i_wr_ready,
  input wire logic i_wr_fail,
  output logic o_prog_end,
  input wire logic i_erase_req,
  input wire logic [7:0] i_flash_key,
  input wire logic [7:0] i_erase_block,
  input wire logic [7:0] i_array_select,
  input wire logic i_branch_altered,
  output logic o_erase_start,
  output logic [7:0] o_erase_block,
  input wire logic i_erase_done,
  input wire logic i_erase_fail,
  output logic o_erase_busy,
  output logic o_erase_exec_error,
  output logic o_key_check_error,
  output logic o_block_select_error,
  output logic o_success_fail_flag
);
  localparam logic [7:0] LAST = 8'(PROG_BYTES - 1);

  fpec_main_t r, n;
  logic [7:0] data_buf [PROG_BYTES];
  logic take;
  logic [7:0] total;
  logic [31:0] next_addr;
  logic [31:0] offset;
  logic addr_bad;
  logic beat;

  // ----------------------------------------
  // Erase checker
  // ----------------------------------------
  fpec_erase_if erase ();
  assign erase.req = i_erase_req;
  assign erase.key = i_flash_key;
  assign erase.block = i_erase_block;
  assign erase.select = i_array_select;
  assign erase.altered = i_branch_altered;
  assign erase.done = i_erase_done;
  assign erase.fail = i_erase_fail;

  fpec_erase_check #(.NUM_BLOCKS(NUM_BLOCKS)) u_erase (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .erase(erase)
  );

  // Block number held from the last request seen while the checker is idle; start is a registered pulse
  assign o_erase_block = r.erase_block;
  assign o_erase_start = erase.start;
  assign o_erase_busy = erase.busy;
  assign o_erase_exec_error = erase.exec_err;
  assign o_key_check_error = erase.key_err;
  assign o_block_select_error = erase.blk_err;
  assign o_success_fail_flag = erase.success_fail;

  // ----------------------------------------
  // Receive side helpers
  // ----------------------------------------
  // Receiving stalls while writing or answering so no byte is lost
  assign o_rx_ready = (r.st == ST_CMD) || (r.st == ST_ADDR) || (r.st == ST_DATA) || (r.st == ST_SUM);
  assign take = i_rx_valid && o_rx_ready;
  assign total = r.sum + i_rx_data;
  assign next_addr = {r.addr[23:0], i_rx_data};
  assign offset = r.addr - i_array_base;
  // Misalignment is treated as an address error too
  assign addr_bad = (r.addr < i_array_base) || (offset > (i_array_size - 32'(PROG_BYTES)))
                    || ((r.addr[7:0] != `FPEC_ALIGN_LO0) && (r.addr[7:0] != `FPEC_ALIGN_LO1));
  assign beat = r.wr_valid && i_wr_ready;

  // ----------------------------------------
  // Command sequencer
  // ----------------------------------------
  always_comb
  begin
    n = r;
    n.prog_end = 1'b0;
    // Block number kept for every request made while the checker is not busy, accepted or not
    if (i_erase_req && !erase.busy)
      n.erase_block = i_erase_block;
    unique case (r.st)
      ST_CMD:
      begin
        // R6: only the programming code opens a command
        if (take && i_rx_data == `FPEC_CMD_PROG)
        begin
          n.st = ST_ADDR;
          n.cnt = 8'h00;
          n.sum = i_rx_data;
          n.addr = 32'h00000000;
        end
      end
      ST_ADDR:
      begin
        if (take)
        begin
          // R6: address arrives most significant byte first
          n.addr = next_addr;
          n.sum = total;
          n.cnt = r.cnt + 8'h01;
          if (r.cnt[1:0] == `FPEC_ADDR_BYTES)
          begin
            n.cnt = 8'h00;
            // R9: end code carries no data
            n.st = (next_addr == `FPEC_END_ADDR) ? ST_SUM : ST_DATA;
          end
        end
      end
      ST_DATA:
      begin
        if (take)
        begin
          n.sum = total;
          n.cnt = r.cnt + 8'h01;
          if (r.cnt == LAST)
          begin
            n.cnt = 8'h00;
            n.st = ST_SUM;
          end
        end
      end
      ST_SUM:
      begin
        if (take)
        begin
          // R13: whole command must sum to zero
          if (total != 8'h00)
          begin
            // R12: checksum code
            n.code = `FPEC_CODE_SUM;
            n.st = ST_ERR;
            n.tx_valid = 1'b1;
            n.tx_data = `FPEC_RESP_ERR;
          end
          // R9: end of array programming
          else if (r.addr == `FPEC_END_ADDR)
          begin
            n.prog_end = 1'b1;
            n.st = ST_CMD;
          end
          // R14: no write on address error
          else if (addr_bad)
          begin
            n.code = `FPEC_CODE_ADDR;
            n.st = ST_ERR;
            n.tx_valid = 1'b1;
            n.tx_data = `FPEC_RESP_ERR;
          end
          else
          begin
            n.st = ST_WRITE;
            n.wfail = 1'b0;
            n.wr_valid = 1'b1;
            n.wr_addr = r.addr;
            n.wr_data = data_buf[0];
          end
        end
      end
      ST_WRITE:
      begin
        if (beat)
        begin
          n.wfail = r.wfail | i_wr_fail;
          n.cnt = r.cnt + 8'h01;
          n.wr_addr = r.wr_addr + 32'h00000001;
          n.wr_data = data_buf[7'(r.cnt + 8'h01)];
          if (r.cnt == LAST)
          begin
            n.wr_valid = 1'b0;
            n.cnt = 8'h00;
            n.tx_valid = 1'b1;
            // R10: acknowledge only a clean write
            n.st = (r.wfail | i_wr_fail) ? ST_ERR : ST_ACK;
            n.tx_data = (r.wfail | i_wr_fail) ? `FPEC_RESP_ERR : `FPEC_RESP_ACK;
            // R12: write failure code
            n.code = `FPEC_CODE_PROG;
          end
        end
      end
      ST_ACK:
      begin
        if (i_tx_ready)
        begin
          n.tx_valid = 1'b0;
          n.st = ST_CMD;
        end
      end
      ST_ERR:
      begin
        // R11: error byte then its code
        if (i_tx_ready)
        begin
          n.tx_data = r.code;
          n.st = ST_CODE;
        end
      end
      ST_CODE:
      begin
        if (i_tx_ready)
        begin
          n.tx_valid = 1'b0;
          n.st = ST_CMD;
        end
      end
    endcase
  end

  // Single state register
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
      r <= '0;
    else
      r <= n;
  end

  // Command data held until the checksum clears it for writing
  always_ff @(posedge i_ref_clk)
  begin
    if (r.st == ST_DATA && take)
      data_buf[7'(r.cnt)] <= i_rx_data;
  end

  assign o_tx_valid = r.tx_valid;
  assign o_tx_data = r.tx_data;
  assign o_wr_valid = r.wr_valid;
  assign o_wr_addr = r.wr_addr;
  assign o_wr_data = r.wr_data;
  assign o_prog_end = r.prog_end;

  // ----------------------------------------
  // Checks on behaviour
  // ----------------------------------------
  cmd_open_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R6
    (r.st == ST_CMD && take && i_rx_data == `FPEC_CMD_PROG) |=> (r.st == ST_ADDR && r.cnt == 8'h00))
    else $error("program code did not open a command");
  sum_error_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R13
    (r.st == ST_SUM && take && total != 8'h00)
      |=> (r.st == ST_ERR && o_tx_valid && o_tx_data == `FPEC_RESP_ERR && r.code == `FPEC_CODE_SUM))
    else $error("checksum mismatch not reported");
  end_prog_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R9
    (r.st == ST_SUM && take && total == 8'h00 && r.addr == `FPEC_END_ADDR)
      |=> (o_prog_end && r.st == ST_CMD && !o_wr_valid))
    else $error("end command mishandled");
  no_write_err_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R14
    (r.st == ST_SUM && take && (total != 8'h00 || addr_bad)) |=> !o_wr_valid [*2])
    else $error("flash written after command error");
  ack_byte_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R10
    (r.st == ST_ACK) |-> (o_tx_valid && o_tx_data == `FPEC_RESP_ACK && !r.wfail))
    else $error("acknowledge byte wrong");
  err_code_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R11
    (r.st == ST_ERR && i_tx_ready) |=> (r.st == ST_CODE && o_tx_data == $past(r.code) && o_tx_valid))
    else $error("error code did not follow error byte");
  code_value_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R12
    (r.st == ST_CODE) |-> (r.code inside {`FPEC_CODE_SUM, `FPEC_CODE_ADDR, `FPEC_CODE_PROG}))
    else $error("unknown error code");
endmodule : fpec_top

/* File: tb/fpec_host_model.sv */
// Host model: sends programming commands and collects answer bytes.
// Assumes the bench top is tb and drives this model just after clock edges.
`timescale 1ns/10ps
module fpec_host_model (
  input wire logic i_ref_clk,
  input wire logic i_rx_ready,
  input wire logic i_tx_valid,
  input wire logic [7:0] i_tx_data,
  output logic o_rx_valid,
  output logic [7:0] o_rx_data,
  output logic o_tx_ready
);
  logic [7:0] sent [0:127];
  int slow = 0;

  // Idle line shows a pattern, never a stale byte
  initial
  begin
    o_rx_valid = 1'b0;
    o_rx_data = 8'hA5;
    o_tx_ready = 1'b0;
  end

  // ----------------------------------------
  // Byte transfer
  // ----------------------------------------
  // Byte held until the edge that sees ready high
  task send_byte(input logic [7:0] b);
    logic rdy;
    int n;
    begin
      n = 0;
      rdy = 1'b0;
      o_rx_valid = 1'b1;
      o_rx_data = b;
      while (!rdy)
      begin
        rdy = (i_rx_ready === 1'b1);
        @(posedge i_ref_clk);
        #1;
        n++;
        if (n > 3000) tb.hang();
      end
    end
  endtask : send_byte

  task send_prog(input logic [31:0] a, input int n, input logic bad);
    logic [7:0] s;
    begin
      s = 8'h50;
      send_byte(8'h50);
      for (int i = 3; i >= 0; i--)
      begin
        send_byte(a[8*i +: 8]);
        s += a[8*i +: 8];
      end
      if (a != 32'hFFFFFFFF)
        for (int k = 0; k < 128; k++)
        begin
          sent[k] = (k < n) ? ((a[7:0] + k[7:0]) ^ 8'h3C) : 8'hFF;
          send_byte(sent[k]);
          s += sent[k];
        end
      send_byte(8'h00 - s + {7'h00, bad});
      o_rx_valid = 1'b0;
      o_rx_data = ~o_rx_data;
    end
  endtask : send_prog

  // Takes the byte at the edge where valid and ready are both high
  task recv_byte(output logic [7:0] b);
    int n;
    begin
      n = 0;
      while (i_tx_valid !== 1'b1)
      begin
        @(posedge i_ref_clk);
        #1;
        n++;
        if (n > 3000) tb.hang();
      end
      // One idle cycle minimum keeps ready from toggling twice in a step
      repeat (slow + 1)
      begin
        @(posedge i_ref_clk);
        #1;
      end
      o_tx_ready = 1'b1;
      b = i_tx_data;
      @(posedge i_ref_clk);
      #1;
      o_tx_ready = 1'b0;
    end
  endtask : recv_byte
endmodule : fpec_host_model

/* File: tb/tb.sv */
// Self-checking bench for the flash program/erase control top.
// Assumes the host model file and the design files are compiled first.
`timescale 1ns/10ps
`define CHK(nm, exp, got) \
  begin \
    checked++; \
    if ((got) !== (exp)) \
    begin \
      errors++; \
      $display("Error %s expected %h seen %h", nm, exp, got); \
    end \
  end
module tb;
  localparam logic [31:0] BASE = 32'h0001_0000;
  localparam logic [31:0] SIZE = 32'h0000_1000;
  logic ref_clk, rst_n, rx_valid, rx_ready, tx_valid, tx_ready, wr_valid, wr_ready, wr_fail, prog_end;
  logic [7:0] rx_data, tx_data, wr_data, r, flash_key, erase_block, array_select, erase_block_o;
  logic [31:0] wr_addr, cur_addr;
  logic erase_req, branch_alt, erase_start, erase_done, erase_fail, erase_busy, exec_err, key_err, blk_err;
  logic success_fail;
  logic stall = 1'b0;
  int errors = 0;
  int checked = 0;
  int beats = 0;
  int b0 = 0;
  int fail_idx = 999;
  int ends = 0;

  // 125 MHz clock
  initial ref_clk = 1'b0;
  always #4 ref_clk = ~ref_clk;

  fpec_top i_fpec_top (.i_ref_clk(ref_clk), .i_rst_n(rst_n), .i_rx_valid(rx_valid), .i_rx_data(rx_data),
    .o_rx_ready(rx_ready), .o_tx_valid(tx_valid), .o_tx_data(tx_data), .i_tx_ready(tx_ready),
    .i_array_base(BASE), .i_array_size(SIZE), .o_wr_valid(wr_valid), .o_wr_addr(wr_addr),
    .o_wr_data(wr_data), .i_wr_ready(wr_ready), .i_wr_fail(wr_fail), .o_prog_end(prog_end),
    .i_erase_req(erase_req), .i_flash_key(flash_key), .i_erase_block(erase_block),
    .i_array_select(array_select), .i_branch_altered(branch_alt), .o_erase_start(erase_start),
    .o_erase_block(erase_block_o), .i_erase_done(erase_done), .i_erase_fail(erase_fail),
    .o_erase_busy(erase_busy), .o_erase_exec_error(exec_err), .o_key_check_error(key_err),
    .o_block_select_error(blk_err), .o_success_fail_flag(success_fail));

  fpec_host_model i_fpec_host_model (.i_ref_clk(ref_clk), .i_rx_ready(rx_ready), .i_tx_valid(tx_valid),
    .i_tx_data(tx_data), .o_rx_valid(rx_valid), .o_rx_data(rx_data), .o_tx_ready(tx_ready));

  // ----------------------------------------
  // Flash write port model
  // ----------------------------------------
  // Stall pattern exercises the hold-until-taken behaviour
  always @(posedge ref_clk)
  begin
    #1;
    wr_ready = stall ? ~wr_ready : 1'b1;
    wr_fail = ((beats - b0) == fail_idx);
  end

  // Beats must ascend from the command address with the sent bytes
  always @(posedge ref_clk)
  begin
    if (prog_end === 1'b1) ends <= ends + 1;
    if (wr_valid === 1'b1 && wr_ready === 1'b1)
    begin
      `CHK("wr_addr", cur_addr + (beats - b0), wr_addr)
      `CHK("wr_data", i_fpec_host_model.sent[beats - b0], wr_data)
      beats <= beats + 1;
    end
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task print_verdict();
    begin
      $display("Comparisons %0d mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask : print_verdict

  task hang();
    begin
      errors++;
      $display("Error handshake expected done seen timeout");
      print_verdict();
    end
  endtask : hang

  // Code 00 means an acknowledge is expected
  task prog(input logic [31:0] a, input int n, input logic bad, input int fi, input logic [7:0] code, input int nb);
    begin
      cur_addr = a;
      b0 = beats;
      fail_idx = fi;
      i_fpec_host_model.send_prog(a, n, bad);
      i_fpec_host_model.recv_byte(r);
      if (code == 8'h00)
        `CHK("ack", 8'h06, r)
      else
      begin
        `CHK("err_resp", 8'hD0, r)
        i_fpec_host_model.recv_byte(r);
        `CHK("err_code", code, r)
      end
      `CHK("beats", nb, beats - b0)
    end
  endtask : prog

  // ex holds start, exec, key, block, success/fail
  task erase(input logic [7:0] k, input logic [7:0] b, input logic [7:0] s, input logic alt, input logic fl,
             input logic [4:0] ex);
    begin
      erase_req = 1'b1;
      flash_key = k;
      erase_block = b;
      array_select = s;
      @(posedge ref_clk);
      #1;
      erase_req = 1'b0;
      branch_alt = alt;
      `CHK("start", ex[4], erase_start)
      `CHK("erase_block", b, erase_block_o)
      if (ex[4])
      begin
        @(posedge ref_clk);
        #1;
        `CHK("busy", 1'b1, erase_busy)
        // A bad request while busy must leave the flags alone
        erase_req = 1'b1;
        flash_key = 8'h00;
        @(posedge ref_clk);
        #1;
        erase_req = 1'b0;
        flash_key = k;
        erase_done = 1'b1;
        erase_fail = fl;
        @(posedge ref_clk);
        #1;
        erase_done = 1'b0;
        erase_fail = 1'b0;
        @(posedge ref_clk);
        #1;
      end
      `CHK("busy_end", 1'b0, erase_busy)
      `CHK("exec_err", ex[3], exec_err)
      `CHK("key_err", ex[2], key_err)
      `CHK("blk_err", ex[1], blk_err)
      `CHK("success_fail", ex[0], success_fail)
      branch_alt = 1'b0;
      // Idle cycle so the next request never toggles in the same step
      @(posedge ref_clk);
      #1;
    end
  endtask : erase

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    rst_n = 1'b0;
    erase_req = 1'b0;
    branch_alt = 1'b0;
    erase_done = 1'b0;
    erase_fail = 1'b0;
    flash_key = 8'h00;
    erase_block = 8'h00;
    array_select = 8'h00;
    repeat (5) @(posedge ref_clk);
    #1;
    rst_n = 1'b1;
    `CHK("rx_ready", 1'b1, rx_ready)
    `CHK("tx_valid", 1'b0, tx_valid)
    erase(8'h5A, 8'h00, 8'h00, 1'b0, 1'b0, 5'b10000);
    erase(8'h5A, 8'h07, 8'h00, 1'b0, 1'b1, 5'b11001);
    erase(8'h5A, 8'h03, 8'h00, 1'b1, 1'b0, 5'b11001);
    erase(8'h00, 8'h00, 8'h00, 1'b0, 1'b0, 5'b00101);
    erase(8'h5A, 8'h08, 8'h00, 1'b0, 1'b0, 5'b00011);
    erase(8'h5A, 8'h00, 8'hAA, 1'b0, 1'b0, 5'b01001);
    // Stray byte before the opcode is dropped
    i_fpec_host_model.send_byte(8'h33);
    prog(BASE, 128, 1'b0, 999, 8'h00, 128);
    stall = 1'b1;
    i_fpec_host_model.slow = 3;
    prog(BASE + 32'h80, 20, 1'b0, 999, 8'h00, 128);
    prog(BASE, 128, 1'b0, 5, 8'h53, 128);
    stall = 1'b0;
    i_fpec_host_model.slow = 0;
    prog(BASE, 128, 1'b1, 999, 8'h11, 0);
    prog(BASE + 32'h40, 128, 1'b0, 999, 8'h2A, 0);
    prog(BASE + SIZE, 128, 1'b0, 999, 8'h2A, 0);
    prog(BASE - 32'h80, 128, 1'b0, 999, 8'h2A, 0);
    i_fpec_host_model.send_prog(32'hFFFFFFFF, 0, 1'b0);
    repeat (4) @(posedge ref_clk);
    #1;
    `CHK("prog_end", 1, ends)
    `CHK("end_tx", 1'b0, tx_valid)
    prog(BASE + 32'h80, 128, 1'b0, 999, 8'h00, 128);
    print_verdict();
  end
endmodule : tb
